// file: include/frc_pkg.sv
/*
  shared constants and carrier types for the flash rewrite controller.
  assumes a single 25 MHz clock domain and a byte-addressed register port.
*/
package frc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned IRQ_W  = 3;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_MODE_ZERO  = 16'h0057;
  localparam logic [ADDR_W-1:0] OFS_MODE_ONE   = 16'h0055;
  localparam logic [ADDR_W-1:0] OFS_MODE_THREE = 16'h0053;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT   = 16'h0060;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 16'h0061;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_READY       = 0;
  localparam int unsigned BIT_REWRITE_EN  = 1;
  localparam int unsigned BIT_LOCK_DIS    = 2;
  localparam int unsigned BIT_MODE_SECOND = 1;
  localparam int unsigned IRQ_FORCED      = 0;
  localparam int unsigned IRQ_REFUSED     = 1;
  localparam int unsigned IRQ_DONE        = 2;

  // ----------------------------------------------------------------
  // reset values and fixed patterns
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0]  RST_MODE_ZERO  = 8'h00;
  localparam logic [REG_W-1:0]  RST_MODE_ONE   = 8'h00;
  localparam logic [REG_W-1:0]  RST_MODE_THREE = 8'h00;
  localparam logic [IRQ_W-1:0]  RST_IRQ        = 3'h0;
  localparam logic [REG_W-1:0]  UPPER_CLEAR    = 8'h00;
  localparam logic [DATA_W-1:0] RD_ZERO        = 16'h0000;

  // ----------------------------------------------------------------
  // register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic              word;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } frc_req_s;

endpackage

// file: core/frc_top.sv
/*
  flash rewrite controller: flash mode registers zero/one/three, the
  two-step arming of the rewrite enable and lock-disable bits, forced
  initialization with abort on non-maskable events, and an interrupt.
  assumes the cpu core drives the register port on ref_clk_i, the flash
  core reports busy and read-array state on the same clock, and only the
  nmi pin is asynchronous.
*/
// Implementation choices: the plain strobed port and the register offsets.
// Overview of operation
// RULE_01 - host slows cpu clock to 10 MHz and one wait before access; the bench clocks the host at 25 MHz with no wait
// RULE_02 - non-maskable events reset mode registers and abort erase or program
// RULE_03 - second mode: no peripheral interrupts or dma during erase or program
// RULE_04 - first mode: no address-match interrupt; handlers and vectors in ram
// RULE_05 - enable bits set only by byte write 0 then 1, uninterrupted, nmi high
// RULE_06 - enable cleared only by word write at 0057h, upper byte 00h, read array
// RULE_07 - commands and data go to even user rom addresses
// RULE_08 - erase after aborted erase needs lock-disable set first
// RULE_09 - clear rewrite enable before wait instruction
// RULE_10 - clear rewrite enable, set stop bit, then short jump
// RULE_11 - no program, erase or lock/protect commands while main clock stopped
// RULE_12 - boot power-up order: reset and boot select low, straps, then release
// RULE_13 - second mode: never rewrite the block holding the control program
// RULE_14 - first mode: avoid instructions that fetch from flash
module frc_top
  import frc_pkg::*;
(
  // clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    arst_n_i,
  // register port
  input  wire frc_pkg::frc_req_s       req_i,
  output logic [frc_pkg::DATA_W-1:0]   rdata_o,
  // non-maskable event sources
  input  wire logic                    nmi_n_i,
  input  wire logic                    wdog_req_i,
  input  wire logic                    wdog_irq_sel_i,
  input  wire logic                    vmon_req_i,
  input  wire logic                    osc_stop_req_i,
  // cpu interrupt and dma activity
  input  wire logic                    intervene_i,
  // flash core status and control
  input  wire logic                    op_busy_i,
  input  wire logic                    read_array_i,
  output logic                         abort_o,
  output logic                         rewrite_en_o,
  output logic                         lock_dis_o,
  output logic                         mode_second_o,
  output logic [frc_pkg::REG_W-1:0]    mode_three_o,
  // interrupt
  output logic                         irq_o
);
  import frc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic              rewrite_en;
  logic              lock_dis;
  logic [REG_W-1:0]  mode_one;
  logic [REG_W-1:0]  mode_three;
  logic              arm_re;
  logic              arm_ld;
  logic              nmi_s1;
  logic              nmi_s2;
  logic              nmi_prev;
  logic              busy_prev;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic              wr_zero_byte;
  logic              wr_zero_word;
  logic              wr_one;
  logic              wr_three;
  logic              wr_mask;
  logic              rd_stat;
  logic [REG_W-1:0]  wb;
  logic              nmi_fall;
  logic              wdog_hit;
  logic              forced;
  logic              set_re;
  logic              set_ld;
  logic              clear_re;
  logic              clear_ld;
  logic              refused;
  logic              done_evt;
  logic [IRQ_W-1:0]  evt;

  assign wb           = req_i.wdata[REG_W-1:0];
  assign wr_zero_byte = req_i.wr & ~req_i.word & (req_i.addr == OFS_MODE_ZERO);
  assign wr_zero_word = req_i.wr & req_i.word & (req_i.addr == OFS_MODE_ZERO);
  assign wr_one       = req_i.wr & (req_i.addr == OFS_MODE_ONE);
  assign wr_three     = req_i.wr & (req_i.addr == OFS_MODE_THREE);
  assign wr_mask      = req_i.wr & (req_i.addr == OFS_IRQ_MASK);
  assign rd_stat      = req_i.rd & (req_i.addr == OFS_IRQ_STAT);

  // ----------------------------------------------------------------
  // nmi pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nmi_s1   <= 1'b1;
      nmi_s2   <= 1'b1;
      nmi_prev <= 1'b1;
    end else begin
      nmi_s1   <= nmi_n_i;
      nmi_s2   <= nmi_s1;
      nmi_prev <= nmi_s2;
    end
  end

  assign nmi_fall = nmi_prev & ~nmi_s2;

  // RULE_02 watchdog qualification
  // in the second mode the watchdog only counts when routed as non-maskable
  assign wdog_hit = wdog_req_i & (~mode_one[BIT_MODE_SECOND] | wdog_irq_sel_i);

  // RULE_02 forced initialization
  assign forced = rewrite_en & (nmi_fall | wdog_hit | vmon_req_i | osc_stop_req_i);

  // RULE_05 second step of arming
  // nmi level taken from the synchronised copy, so a late pin edge may still slip
  assign set_re = wr_zero_byte & wb[BIT_REWRITE_EN] & ~rewrite_en & arm_re
                  & nmi_s2 & ~intervene_i;
  assign set_ld = wr_zero_byte & wb[BIT_LOCK_DIS] & ~lock_dis & arm_ld
                  & nmi_s2 & ~intervene_i;

  // RULE_06 word-wide clear of rewrite enable
  assign clear_re = wr_zero_word & ~wb[BIT_REWRITE_EN]
                    & (req_i.wdata[DATA_W-1:REG_W] == UPPER_CLEAR) & read_array_i;
  assign clear_ld = (wr_zero_byte | wr_zero_word) & ~wb[BIT_LOCK_DIS];

  assign refused = (wr_zero_byte & wb[BIT_REWRITE_EN] & ~rewrite_en & ~set_re)
                 | (wr_zero_byte & wb[BIT_LOCK_DIS] & ~lock_dis & ~set_ld)
                 | (rewrite_en & (wr_zero_byte | wr_zero_word)
                    & ~wb[BIT_REWRITE_EN] & ~clear_re);

  assign done_evt = busy_prev & ~op_busy_i;

  always_comb begin
    evt              = '0;
    evt[IRQ_FORCED]  = forced;
    evt[IRQ_REFUSED] = refused;
    evt[IRQ_DONE]    = done_evt;
  end

  // ----------------------------------------------------------------
  // arming flags
  // ----------------------------------------------------------------
  // RULE_05 first step and its cancellation
  // any other write or any interrupt or dma in between drops the arm
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arm_re <= 1'b0;
      arm_ld <= 1'b0;
    end else if (forced || intervene_i) begin
      arm_re <= 1'b0;
      arm_ld <= 1'b0;
    end else if (req_i.wr) begin
      arm_re <= wr_zero_byte & ~wb[BIT_REWRITE_EN] & ~rewrite_en;
      arm_ld <= wr_zero_byte & ~wb[BIT_LOCK_DIS] & ~lock_dis;
    end
  end

  // ----------------------------------------------------------------
  // flash mode register zero
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rewrite_en <= RST_MODE_ZERO[BIT_REWRITE_EN];
    end else if (forced) begin
      // RULE_02 initialize register zero
      rewrite_en <= RST_MODE_ZERO[BIT_REWRITE_EN];
    end else if (set_re) begin
      rewrite_en <= 1'b1;
    end else if (clear_re) begin
      rewrite_en <= 1'b0;
    end
  end

  // RULE_08 lock-disable for re-erase
  // the flash core uses lock_dis_o to override a lock left by an aborted erase
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lock_dis <= RST_MODE_ZERO[BIT_LOCK_DIS];
    end else if (forced) begin
      lock_dis <= RST_MODE_ZERO[BIT_LOCK_DIS];
    end else if (set_ld) begin
      lock_dis <= 1'b1;
    end else if (clear_ld) begin
      lock_dis <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // flash mode registers one and three
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_one   <= RST_MODE_ONE;
      mode_three <= RST_MODE_THREE;
    end else if (forced) begin
      // RULE_02 initialize registers one and three
      mode_one   <= RST_MODE_ONE;
      mode_three <= RST_MODE_THREE;
    end else begin
      if (wr_one) begin
        mode_one <= wb;
      end
      if (wr_three) begin
        mode_three <= wb;
      end
    end
  end

  // ----------------------------------------------------------------
  // abort and flash-facing outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      abort_o       <= 1'b0;
      busy_prev     <= 1'b0;
      rewrite_en_o  <= RST_MODE_ZERO[BIT_REWRITE_EN];
      lock_dis_o    <= RST_MODE_ZERO[BIT_LOCK_DIS];
      mode_second_o <= RST_MODE_ONE[BIT_MODE_SECOND];
      mode_three_o  <= RST_MODE_THREE;
    end else begin
      // RULE_02 abort running erase or program
      abort_o       <= forced & op_busy_i;
      busy_prev     <= op_busy_i;
      rewrite_en_o  <= rewrite_en;
      lock_dis_o    <= lock_dis;
      mode_second_o <= mode_one[BIT_MODE_SECOND];
      mode_three_o  <= mode_three;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // a new event in the clearing read cycle survives the clear
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat <= RST_IRQ;
    end else if (rd_stat) begin
      irq_stat <= evt;
    end else begin
      irq_stat <= irq_stat | evt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_mask <= RST_IRQ;
    end else if (wr_mask) begin
      irq_mask <= wb[IRQ_W-1:0];
    end
  end

  // one cycle behind status; cheaper than a combinational output path
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = RD_ZERO;
    if (req_i.rd) begin
      case (req_i.addr)
        OFS_MODE_ZERO: begin
          next_rdata[BIT_READY]      = ~op_busy_i;
          next_rdata[BIT_REWRITE_EN] = rewrite_en;
          next_rdata[BIT_LOCK_DIS]   = lock_dis;
        end
        OFS_MODE_ONE: begin
          next_rdata[REG_W-1:0] = mode_one;
        end
        OFS_MODE_THREE: begin
          next_rdata[REG_W-1:0] = mode_three;
        end
        OFS_IRQ_STAT: begin
          next_rdata[IRQ_W-1:0] = irq_stat;
        end
        OFS_IRQ_MASK: begin
          next_rdata[IRQ_W-1:0] = irq_mask;
        end
        default: begin
          next_rdata = RD_ZERO;
        end
      endcase
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= RD_ZERO;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule

// file: verif/frc_top_sva.sv
/*
  checker for the flash rewrite controller top ports.
  assumes one clock domain and the registered output timing of the hand-over.
*/
module frc_top_chk
  import frc_pkg::*;
(
  // clock and reset
  input wire logic              ref_clk_i,
  input wire logic              arst_n_i,
  // watched ports
  input wire frc_pkg::frc_req_s req_i,
  input wire logic              nmi_n_i,
  input wire logic              wdog_req_i,
  input wire logic              vmon_req_i,
  input wire logic              osc_stop_req_i,
  input wire logic              intervene_i,
  input wire logic              op_busy_i,
  input wire logic              read_array_i,
  input wire logic              abort_o,
  input wire logic              rewrite_en_o,
  input wire logic              lock_dis_o,
  input wire logic              mode_second_o,
  input wire logic [7:0]        mode_three_o,
  input wire logic              irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // watchdog left out: its qualifier depends on the mode
  wire forced_c = vmon_req_i | osc_stop_req_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_abort_needs_busy: assert property (abort_o |-> $past(op_busy_i))
    else $error("abort without busy flash");
  a_abort_one_pulse: assert property (abort_o |=> !abort_o)
    else $error("abort longer than one cycle");
  a_forced_abort: assert property (forced_c && rewrite_en_o && op_busy_i && !$past(req_i.wr)
    && !$past(forced_c) |=> abort_o) else $error("forced event did not abort");
  a_forced_clear: assert property (forced_c && rewrite_en_o && !$past(req_i.wr) && !$past(forced_c)
    |-> ##2 (!rewrite_en_o && !lock_dis_o && !mode_second_o && mode_three_o == 8'h00))
    else $error("mode registers not initialized");
  a_enable_set_cause: assert property ($rose(rewrite_en_o) |-> $past(req_i.wr && !req_i.word
    && req_i.addr == OFS_MODE_ZERO && req_i.wdata[1] && !intervene_i, 2))
    else $error("rewrite enable rose without byte write of one");
  a_enable_clear_cause: assert property ($fell(rewrite_en_o) && $past(nmi_n_i) |->
    $past(req_i.wr && req_i.word && req_i.addr == OFS_MODE_ZERO && req_i.wdata[15:8] == UPPER_CLEAR
    && read_array_i, 2) || $past(forced_c || wdog_req_i, 2))
    else $error("rewrite enable fell without word clear");
  a_lock_set_cause: assert property ($rose(lock_dis_o) |-> $past(req_i.wr && !req_i.word
    && req_i.addr == OFS_MODE_ZERO && req_i.wdata[2] && !intervene_i, 2))
    else $error("lock-disable rose without byte write of one");
  c_abort: cover property (abort_o);
  c_enable_set: cover property ($rose(rewrite_en_o));
  c_irq: cover property ($rose(irq_o));
endmodule

bind frc_top frc_top_chk u_chk (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .req_i(req_i),
  .nmi_n_i(nmi_n_i), .wdog_req_i(wdog_req_i), .vmon_req_i(vmon_req_i), .osc_stop_req_i(osc_stop_req_i),
  .intervene_i(intervene_i), .op_busy_i(op_busy_i), .read_array_i(read_array_i), .abort_o(abort_o),
  .rewrite_en_o(rewrite_en_o), .lock_dis_o(lock_dis_o), .mode_second_o(mode_second_o),
  .mode_three_o(mode_three_o), .irq_o(irq_o));

// file: verif/frc_host_model.sv
/*
  cpu core model driving the register port of the rewrite controller.
  assumes tasks are entered in the time step of a rising edge.
*/
module frc_host_model
  import frc_pkg::*;
(
  // clock
  input  wire logic                   ref_clk_i,
  // register port
  output frc_pkg::frc_req_s           req_o,
  input  wire logic [frc_pkg::DATA_W-1:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] last_q;
  initial req_o = '0;
  // ----------------------------------------------------------------
  // access
  // ----------------------------------------------------------------
  // clock not slowed: host runs on the 25 MHz ref_clk_i, not 10 MHz
  // no flash-fetching instructions
  // idle cycle after each strobe so no strobe is assigned twice at one edge
  task automatic acc(input logic w, r, wd, input logic [15:0] a, d);
    req_o <= '{wr: w, rd: r, word: wd, addr: a, wdata: d};
    @(posedge ref_clk_i);
    req_o <= '0;
    #1 last_q = rdata_i;
    @(posedge ref_clk_i);
  endtask
  task automatic set_bits(input logic [7:0] v);
    acc(1'b1, 1'b0, 1'b0, OFS_MODE_ZERO, 16'h0000);
    acc(1'b1, 1'b0, 1'b0, OFS_MODE_ZERO, {8'h00, v});
  endtask
  task automatic clear_en();
    acc(1'b1, 1'b0, 1'b1, OFS_MODE_ZERO, {UPPER_CLEAR, 8'h00});
  endtask
endmodule

// file: verif/frc_top_tb.sv
/*
  self-checking bench for the flash rewrite controller.
  assumes the host model drives the register port; bench drives event pins.
*/
module frc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import frc_pkg::*;
  logic ref_clk_i, arst_n_i, nmi_n_i, wdog_req_i, wdog_irq_sel_i, vmon_req_i, osc_stop_req_i;
  logic intervene_i, op_busy_i, read_array_i, abort_o, rewrite_en_o, lock_dis_o, mode_second_o, irq_o;
  logic [7:0]  mode_three_o;
  logic [15:0] rdata_o;
  frc_req_s    req;
  int          error_cnt = 0, samples_checked = 0, abort_cnt = 0, n;
  frc_host_model host (.ref_clk_i(ref_clk_i), .req_o(req), .rdata_i(rdata_o));
  frc_top dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .req_i(req), .rdata_o(rdata_o),
    .nmi_n_i(nmi_n_i), .wdog_req_i(wdog_req_i), .wdog_irq_sel_i(wdog_irq_sel_i), .vmon_req_i(vmon_req_i),
    .osc_stop_req_i(osc_stop_req_i), .intervene_i(intervene_i), .op_busy_i(op_busy_i),
    .read_array_i(read_array_i), .abort_o(abort_o), .rewrite_en_o(rewrite_en_o), .lock_dis_o(lock_dis_o),
    .mode_second_o(mode_second_o), .mode_three_o(mode_three_o), .irq_o(irq_o));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) abort_cnt += abort_o;
  task automatic chk(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [15:0] a, exp);
    host.acc(1'b0, 1'b1, 1'b0, a, 16'h0000);
    chk(host.last_q, exp);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  initial begin
    #400000;
    error_cnt++;
    results();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {nmi_n_i, wdog_irq_sel_i} = 2'b10;
    {wdog_req_i, vmon_req_i, osc_stop_req_i, intervene_i, op_busy_i, read_array_i} = '0;
    arst_n_i = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    host.acc(1'b1, 1'b0, 1'b0, OFS_MODE_ZERO, 16'h0002);
    rchk(OFS_MODE_ZERO, 16'h0001);
    @(negedge ref_clk_i);
    chk({15'h0, irq_o}, 16'h0000);
    @(posedge ref_clk_i);
    host.acc(1'b1, 1'b0, 1'b0, OFS_IRQ_MASK, 16'h0007);
    @(negedge ref_clk_i);
    chk({15'h0, irq_o}, 16'h0001);
    @(posedge ref_clk_i);
    rchk(OFS_IRQ_STAT, 16'h0002);
    @(negedge ref_clk_i);
    chk({15'h0, irq_o}, 16'h0000);
    @(posedge ref_clk_i);
    // arming broken by an interrupt taken between the two writes
    host.acc(1'b1, 1'b0, 1'b0, OFS_MODE_ZERO, 16'h0000);
    intervene_i <= 1'b1;
    @(posedge ref_clk_i);
    intervene_i <= 1'b0;
    host.acc(1'b1, 1'b0, 1'b0, OFS_MODE_ZERO, 16'h0006);
    rchk(OFS_MODE_ZERO, 16'h0001);
    rchk(OFS_IRQ_STAT, 16'h0002);
    host.set_bits(8'h06);
    @(negedge ref_clk_i);
    chk({14'h0, rewrite_en_o, lock_dis_o}, 16'h0003);
    @(posedge ref_clk_i);
    rchk(OFS_MODE_ZERO, 16'h0007);
    // only the word clear in read array mode drops the enable
    host.acc(1'b1, 1'b0, 1'b0, OFS_MODE_ZERO, 16'h0000);
    rchk(OFS_MODE_ZERO, 16'h0003);
    host.acc(1'b1, 1'b0, 1'b1, OFS_MODE_ZERO, 16'h1200);
    rchk(OFS_MODE_ZERO, 16'h0003);
    host.clear_en();
    rchk(OFS_MODE_ZERO, 16'h0003);
    rchk(OFS_IRQ_STAT, 16'h0002);
    read_array_i <= 1'b1;
    host.clear_en();
    rchk(OFS_MODE_ZERO, 16'h0001);
    // forced events: vmon, osc stop, wdog selected, nmi, wdog not selected
    for (int k = 0; k < 5; k++) begin
      host.set_bits(8'h02);
      host.acc(1'b1, 1'b0, 1'b0, OFS_MODE_ONE, 16'h0002);
      host.acc(1'b1, 1'b0, 1'b0, OFS_MODE_THREE, 16'h00a5);
      wdog_irq_sel_i <= (k != 4);
      op_busy_i <= 1'b1;
      n = abort_cnt;
      case (k)
        0: vmon_req_i <= 1'b1;
        1: osc_stop_req_i <= 1'b1;
        2, 4: wdog_req_i <= 1'b1;
        default: nmi_n_i <= 1'b0;
      endcase
      @(posedge ref_clk_i);
      {vmon_req_i, osc_stop_req_i, wdog_req_i} <= 3'b000;
      repeat (8) @(posedge ref_clk_i);
      nmi_n_i <= 1'b1;
      op_busy_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      chk(16'(abort_cnt - n), (k == 4) ? 16'h0000 : 16'h0001);
      chk({7'h00, mode_second_o, mode_three_o}, (k == 4) ? 16'h01a5 : 16'h0000);
      rchk(OFS_MODE_THREE, (k == 4) ? 16'h00a5 : 16'h0000);
      rchk(OFS_MODE_ONE, (k == 4) ? 16'h0002 : 16'h0000);
      if (k == 4) host.clear_en();
    end
    rchk(OFS_IRQ_STAT, 16'h0005);
    // nmi held low blocks the second step
    nmi_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    host.set_bits(8'h02);
    rchk(OFS_MODE_ZERO, 16'h0001);
    nmi_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    // re-erase after abort needs lock-disable first
    host.set_bits(8'h06);
    rchk(OFS_MODE_ZERO, 16'h0007);
    results();
  end
endmodule
